/* File: rtl/pswq_pkg.sv */
// shared constants and types for the program segment wait sequencer
package pswq_pkg;
    // clock rate and time base
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned TICK_PERIOD_MS = 1000;          // scaling below gives a one millisecond time base (TICK_CYCLES = 10000)
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_PERIOD_MS / 1000;
    localparam int unsigned SECS_PER_MIN  = 60;

    // value widths
    localparam int unsigned VAL_W   = 16;                   // measured value in 0.1 % of span
    localparam int unsigned BAND_W  = 7;                    // band width in 0.1 % of span
    localparam logic [BAND_W-1:0] BAND_MAX = 7'h64;         // 10.0 % of span
    localparam logic [BAND_W-1:0] BAND_RESET = 7'h00;

    // timeout: major part 0..999, minor part 0..59
    localparam int unsigned MAJ_W = 10;
    localparam int unsigned MIN_W = 6;
    localparam logic [MAJ_W-1:0] MAJ_MAX = 10'h3E7;         // 999
    localparam logic [MIN_W-1:0] MIN_MAX = 6'h3B;           // 59
    localparam logic [15:0] PROG_TIME_RESET = 16'h0000;

    // per-segment end action codes
    typedef enum logic [3:0] {
        plain_continue    = 4'h0,
        hold_at_end       = 4'h1,
        switch_to_local   = 4'h2,
        wait_at_switch    = 4'h3,
        wait_in_interval  = 4'h4,
        release_then_local = 4'h5,
        link_pattern_one  = 4'h6,
        link_pattern_two  = 4'h7,
        link_pattern_three = 4'h8,
        link_pattern_four = 4'h9
    } pswq_action_type;

    // program time unit
    typedef enum logic {
        hour_minute_unit   = 1'b0,
        minute_second_unit = 1'b1
    } pswq_unit_type;

    // wait settings carried together
    typedef struct packed {
        logic               wait_enable;
        logic [BAND_W-1:0]  upper_band_width;
        logic [BAND_W-1:0]  lower_band_width;
        logic               timeout_off;
        logic [MAJ_W-1:0]   timeout_major;
        logic [MIN_W-1:0]   timeout_minor;
        pswq_unit_type      program_time_unit;
    } pswq_cfg_type;

    // sequencer state
    typedef enum logic [1:0] {
        ST_RUN      = 2'b00,
        ST_WAIT_SW  = 2'b01,
        ST_WAIT_IV  = 2'b10
    } pswq_state_type;
endpackage

/* File: rtl/pswq_band.sv */
// window comparator: is the measured value inside the wait band
`timescale 1ns/10ps
module pswq_band (
    input  wire logic [15:0] measured_value,   // measured value
    input  wire logic [15:0] target,           // band centre
    input  wire logic [6:0]  upper_band_width, // upper width
    input  wire logic [6:0]  lower_band_width, // lower width
    output logic             in_band           // inside band, combinational
);
    logic [16:0] hi_lim;
    logic [16:0] lo_lim;

    // widen by one bit so the limits never wrap near the ends of the span
    assign hi_lim  = {1'b0, target} + {10'h000, upper_band_width};
    assign lo_lim  = {1'b0, target} - {10'h000, lower_band_width};
    // inclusive on both edges; negative low limit counts as zero
    assign in_band = ({1'b0, measured_value} <= hi_lim) &&
                     (lo_lim[16] || ({1'b0, measured_value} >= lo_lim));
endmodule

/* File: rtl/pswq_seq.sv */
// program segment wait sequencer: segment-end and mid-segment wait handling
//
// How it works
// - at segment end with wait_at_switch and value outside band, enter wait
// - end-of-segment wait leaves and advances the cycle after value enters band
// - timeout expiry ends the wait and advances regardless of value
// - program time counter is frozen while waiting
// - timeout off means waiting lasts until value enters band
// - wait_in_interval enters wait whenever value leaves band mid-segment
// - mid-segment band centres on the current ramping setpoint
// - mid-segment wait ends and program resumes when value returns inside
// - timeout is ignored during mid-segment waits
// - end action code picks continue, wait at switch or wait in interval
// - hold action keeps end setpoint and keeps controlling there
// - local switch action changes to local setpoint at segment completion
// - release-then-local changes to local only on completion after release
// - link actions continue into another pattern; four with extended option
// - wait function has enable setting, disabled or enabled
// - each band width settable zero to ten percent of span
// - timeout is off or 0.00 to 999.59, minor digits count 0..59
// - timeout counted in hour.minute or minute.second program unit
`timescale 1ns/10ps
module pswq_seq (
    input  wire logic                  clk,                // 10 MHz clock
    input  wire logic                  nrst,               // sync reset, active low
    input  wire logic [15:0]           measured_value,     // measured value
    input  wire logic [15:0]           current_setpoint,   // ramping setpoint now
    input  wire logic [15:0]           segment_target,     // final target of segment
    input  wire logic [15:0]           local_setpoint,     // local setpoint
    input  wire logic                  segment_end,        // pulse: segment time done
    input  wire logic                  release_seen,       // pulse: release command
    input  wire logic                  extended_option,    // four-pattern link option
    input  wire pswq_pkg::pswq_action_type segment_end_action, // end action of segment
    input  wire pswq_pkg::pswq_cfg_type    cfg,            // wait settings
    output logic                       waiting,            // wait state
    output logic                       advance,            // pulse: go to next segment
    output logic                       time_tick,          // pulse: program time step, each 1 ms tick while running
    output logic [15:0]                program_time,       // program time, milliseconds
    output logic                       holding,            // hold end action active
    output logic                       local_mode,         // local setpoint in use
    output logic [15:0]                control_setpoint,   // setpoint to controller
    output logic                       link_valid,         // pulse: link requested
    output logic [1:0]                 link_pattern,       // linked pattern index
    output logic                       cfg_error           // settings out of range
);
    pswq_pkg::pswq_state_type state_reg;
    pswq_pkg::pswq_state_type state_next;
    logic [23:0]  div_reg;
    logic         tick;
    logic [5:0]   sec_reg;
    logic [5:0]   min_reg;
    logic [9:0]   maj_reg;
    logic         minor_step;
    logic         timeout_hit;
    logic         band_sw;
    logic         band_iv;
    logic         wait_on;
    logic         released_reg;
    logic         end_done;
    logic [15:0]  held_sp_reg;
    logic [6:0]   up_w;
    logic [6:0]   lo_w;

    // band widths clamp to ten percent of span
    assign up_w = (cfg.upper_band_width > pswq_pkg::BAND_MAX) ?
                  pswq_pkg::BAND_MAX : cfg.upper_band_width;
    assign lo_w = (cfg.lower_band_width > pswq_pkg::BAND_MAX) ?
                  pswq_pkg::BAND_MAX : cfg.lower_band_width;
    assign wait_on = cfg.wait_enable;

    // end-of-segment band centres on segment target
    pswq_band u_band_sw (
        .measured_value   (measured_value),
        .target           (segment_target),
        .upper_band_width (up_w),
        .lower_band_width (lo_w),
        .in_band          (band_sw)
    );

    // mid-segment band centres on the ramping setpoint
    pswq_band u_band_iv (
        .measured_value   (measured_value),
        .target           (current_setpoint),
        .upper_band_width (up_w),
        .lower_band_width (lo_w),
        .in_band          (band_iv)
    );

    // one-millisecond time base divider (10000 cycles at 10 MHz)
    always_ff @(posedge clk) begin
        if (!nrst || div_reg == 24'(pswq_pkg::TICK_CYCLES - 1)) begin
            div_reg <= 24'h000000;
        end else begin
            div_reg <= div_reg + 24'h000001;
        end
    end
    assign tick = (div_reg == 24'(pswq_pkg::TICK_CYCLES - 1));

    // program time runs only while operating
    always_ff @(posedge clk) begin
        if (!nrst) begin
            program_time <= pswq_pkg::PROG_TIME_RESET;
            time_tick    <= 1'b0;
        end else begin
            time_tick <= tick && state_reg == pswq_pkg::ST_RUN;
            if (tick && state_reg == pswq_pkg::ST_RUN) begin
                program_time <= program_time + 16'h0001;
            end
        end
    end

    // minor digit step: every 60 ticks (60 ms) in hour.minute, every tick (1 ms) in minute.second
    assign minor_step = tick && (cfg.program_time_unit == pswq_pkg::minute_second_unit ||
                                 sec_reg == 6'(pswq_pkg::SECS_PER_MIN - 1));

    // wait timer, counts only in end-of-segment waits
    always_ff @(posedge clk) begin
        if (!nrst || state_reg != pswq_pkg::ST_WAIT_SW) begin
            sec_reg <= 6'h00;
            min_reg <= 6'h00;
            maj_reg <= 10'h000;
        end else if (tick) begin
            sec_reg <= (sec_reg == 6'(pswq_pkg::SECS_PER_MIN - 1)) ? 6'h00 : sec_reg + 6'h01;
            if (minor_step) begin
                if (min_reg == pswq_pkg::MIN_MAX) begin
                    min_reg <= 6'h00;
                    maj_reg <= maj_reg + 10'h001;
                end else begin
                    min_reg <= min_reg + 6'h01;
                end
            end
        end
    end

    // expiry; a timeout of 0.00 expires at once, off never expires
    assign timeout_hit = !cfg.timeout_off &&
                         {maj_reg, min_reg} >= {cfg.timeout_major, cfg.timeout_minor};

    // segment end taken with no wait needed
    assign end_done = segment_end &&
        !(wait_on && segment_end_action == pswq_pkg::wait_at_switch && !band_sw);

    // next sequencer state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pswq_pkg::ST_RUN: begin
                if (segment_end && wait_on &&
                    segment_end_action == pswq_pkg::wait_at_switch && !band_sw) begin
                    state_next = pswq_pkg::ST_WAIT_SW;
                end else if (!segment_end && wait_on &&
                    segment_end_action == pswq_pkg::wait_in_interval && !band_iv) begin
                    state_next = pswq_pkg::ST_WAIT_IV;
                end
            end
            pswq_pkg::ST_WAIT_SW: begin
                if (band_sw || timeout_hit || !wait_on) begin
                    state_next = pswq_pkg::ST_RUN;
                end
            end
            pswq_pkg::ST_WAIT_IV: begin
                if (band_iv || !wait_on) begin
                    state_next = pswq_pkg::ST_RUN;
                end
            end
            default: state_next = pswq_pkg::ST_RUN;
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= pswq_pkg::ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // wait and advance outputs, registered
    always_ff @(posedge clk) begin
        if (!nrst) begin
            waiting <= 1'b0;
            advance <= 1'b0;
        end else begin
            waiting <= state_next != pswq_pkg::ST_RUN;
            advance <= (state_reg == pswq_pkg::ST_RUN && end_done) ||
                       (state_reg == pswq_pkg::ST_WAIT_SW &&
                        state_next == pswq_pkg::ST_RUN);
        end
    end

    // release is remembered until the segment completes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            released_reg <= 1'b0;
        end else if (release_seen) begin
            released_reg <= 1'b1; // set wins over the clear below
        end else if (segment_end) begin
            released_reg <= 1'b0;
        end
    end

    // end actions: hold, local switch, pattern link
    always_ff @(posedge clk) begin
        if (!nrst) begin
            holding      <= 1'b0;
            local_mode   <= 1'b0;
            held_sp_reg  <= 16'h0000;
            link_valid   <= 1'b0;
            link_pattern <= 2'h0;
        end else begin
            link_valid <= 1'b0;
            if (end_done && state_reg == pswq_pkg::ST_RUN) begin
                case (segment_end_action)
                    pswq_pkg::hold_at_end: begin
                        holding     <= 1'b1;
                        held_sp_reg <= current_setpoint;
                    end
                    pswq_pkg::switch_to_local: local_mode <= 1'b1;
                    pswq_pkg::release_then_local: begin
                        if (released_reg || release_seen) begin
                            local_mode <= 1'b1;
                        end
                    end
                    pswq_pkg::link_pattern_one: begin
                        link_valid   <= 1'b1;
                        link_pattern <= 2'h0;
                    end
                    pswq_pkg::link_pattern_two: begin
                        link_valid   <= 1'b1;
                        link_pattern <= 2'h1;
                    end
                    pswq_pkg::link_pattern_three, pswq_pkg::link_pattern_four: begin
                        link_valid   <= extended_option;
                        link_pattern <= (segment_end_action == pswq_pkg::link_pattern_three) ?
                                        2'h2 : 2'h3;
                    end
                    default: ;
                endcase
            end
        end
    end

    // setpoint handed to the controller
    always_ff @(posedge clk) begin
        if (!nrst) begin
            control_setpoint <= 16'h0000;
        end else if (local_mode) begin
            control_setpoint <= local_setpoint;
        end else if (holding) begin
            control_setpoint <= held_sp_reg;
        end else begin
            control_setpoint <= current_setpoint;
        end
    end

    // flags settings that lie beyond the documented ranges
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg_error <= 1'b0;
        end else begin
            cfg_error <= cfg.upper_band_width > pswq_pkg::BAND_MAX ||
                         cfg.lower_band_width > pswq_pkg::BAND_MAX ||
                         (!cfg.timeout_off && (cfg.timeout_major > pswq_pkg::MAJ_MAX ||
                          cfg.timeout_minor > pswq_pkg::MIN_MAX));
        end
    end

    // end-of-segment wait, value in band: leave and advance next cycle
    a_sw_band_exit: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == pswq_pkg::ST_WAIT_SW && band_sw |=> advance && !waiting)
        else $error("wait did not end on band entry");
    // entering wait at segment end
    a_sw_entry: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == pswq_pkg::ST_RUN && segment_end && wait_on &&
        segment_end_action == pswq_pkg::wait_at_switch && !band_sw |=> waiting && !advance)
        else $error("no wait at segment end");
    // expiry ends the wait
    a_timeout_exit: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == pswq_pkg::ST_WAIT_SW && timeout_hit |=> advance)
        else $error("timeout did not advance");
    // frozen time while waiting
    a_time_frozen: assert property (@(posedge clk) disable iff (!nrst)
        waiting && state_reg != pswq_pkg::ST_RUN |=> $stable(program_time))
        else $error("program time moved while waiting");
    // off timeout never ends a wait
    a_off_holds: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == pswq_pkg::ST_WAIT_SW && cfg.timeout_off && !band_sw && wait_on
        |=> state_reg == pswq_pkg::ST_WAIT_SW)
        else $error("wait ended with timeout off");
    // mid-segment drift enters wait
    a_iv_entry: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == pswq_pkg::ST_RUN && !segment_end && wait_on &&
        segment_end_action == pswq_pkg::wait_in_interval && !band_iv |=> waiting)
        else $error("no mid-segment wait");
    // mid-segment return resumes without advance
    a_iv_exit: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == pswq_pkg::ST_WAIT_IV && band_iv |=> !waiting && !advance)
        else $error("mid-segment wait did not end");
    // timeout has no say mid-segment
    a_iv_no_tmo: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == pswq_pkg::ST_WAIT_IV && !band_iv && wait_on |=> waiting)
        else $error("mid-segment wait ended early");
    // hold keeps the end setpoint
    a_hold_sp: assert property (@(posedge clk) disable iff (!nrst)
        holding && !local_mode |=> control_setpoint == $past(held_sp_reg))
        else $error("hold setpoint lost");
endmodule

/* File: test/pswq_pv_model.sv */
// partner model: measured value from the input stage, prompt or slewing
`timescale 1ns/10ps
module pswq_pv_model (
    input  wire logic        clk,            // 10 MHz clock
    input  wire logic        nrst,           // sync reset, active low
    input  wire logic [15:0] goal,           // value the process heads for
    input  wire logic        slow,           // slew one count per cycle
    output logic      [15:0] measured_value  // value seen by the sequencer
);
    // slow mode mimics a lagging process so band entry is gradual
    always_ff @(posedge clk) begin
        if (!nrst) begin
            measured_value <= 16'h0000;
        end else if (!slow || measured_value == goal) begin
            measured_value <= goal;
        end else if (measured_value < goal) begin
            measured_value <= measured_value + 16'h0001;
        end else begin
            measured_value <= measured_value - 16'h0001;
        end
    end
endmodule

/* File: test/pswq_seq_tb.sv */
// self-checking bench for the program segment wait sequencer
`timescale 1ns/10ps
module pswq_seq_tb;
    localparam logic [15:0] TGT = 16'h0200;
    logic                      clk, nrst, segment_end, release_seen, extended_option, slow;
    logic [15:0]               measured_value, current_setpoint, segment_target;
    logic [15:0]               local_setpoint, goal, program_time, control_setpoint, pt;
    logic                      waiting, advance, time_tick, holding, local_mode;
    logic                      link_valid, cfg_error;
    logic [1:0]                link_pattern;
    pswq_pkg::pswq_action_type segment_end_action;
    pswq_pkg::pswq_cfg_type    cfg;
    int                        miscompares, tests_run;

    pswq_pv_model i_pswq_pv_model (.clk(clk), .nrst(nrst), .goal(goal), .slow(slow),
        .measured_value(measured_value));

    pswq_seq i_pswq_seq (.clk(clk), .nrst(nrst), .measured_value(measured_value),
        .current_setpoint(current_setpoint), .segment_target(segment_target),
        .local_setpoint(local_setpoint), .segment_end(segment_end),
        .release_seen(release_seen), .extended_option(extended_option),
        .segment_end_action(segment_end_action), .cfg(cfg), .waiting(waiting),
        .advance(advance), .time_tick(time_tick), .program_time(program_time),
        .holding(holding), .local_mode(local_mode), .control_setpoint(control_setpoint),
        .link_valid(link_valid), .link_pattern(link_pattern), .cfg_error(cfg_error));

    // free-running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // land on settled outputs just after an edge
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic set_pv(logic [15:0] v);
        @(posedge clk) goal <= v;
        tick(2);
    endtask

    // segment_end is a one-cycle pulse; returns just after the sampling edge
    task automatic seg_end(pswq_pkg::pswq_action_type a);
        @(posedge clk);
        segment_end_action <= a;
        segment_end <= 1'b1;
        @(posedge clk) segment_end <= 1'b0;
        #1;
    endtask

    // bounded wait for the advance pulse
    task automatic wait_adv(int max);
        for (int i = 0; i < max; i++) begin
            tick(1);
            if (advance === 1'b1) break;
        end
    endtask

    task automatic do_reset();
        @(posedge clk) nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        tick(1);
    endtask

    task automatic sc_switch_wait();
        set_pv(TGT - 16'h0064);
        seg_end(pswq_pkg::wait_at_switch);
        tick(1);
        check("waiting", waiting, 1'b1);
        check("advance", advance, 1'b0);
        pt = program_time;
        tick(200);
        check("waiting", waiting, 1'b1);
        check("program_time", program_time, pt);
        check("time_tick", time_tick, 1'b0);
        // slew up from below so band entry lands on the lower edge
        @(posedge clk);
        slow <= 1'b1;
        goal <= TGT;
        wait_adv(120);
        check("advance", advance, 1'b1);
        check("measured_value", measured_value, TGT - 16'h0013);
        check("waiting", waiting, 1'b0);
        @(posedge clk) slow <= 1'b0;
        set_pv(TGT + 16'h000B);
        seg_end(pswq_pkg::wait_at_switch);
        tick(1);
        check("waiting", waiting, 1'b1);
        set_pv(TGT + 16'h000A);
        check("waiting", waiting, 1'b0);
    endtask

    task automatic sc_timeout();
        @(posedge clk) cfg.timeout_off <= 1'b0;
        set_pv(TGT - 16'h0064);
        seg_end(pswq_pkg::wait_at_switch);
        wait_adv(4);
        check("advance", advance, 1'b1);
        tick(1);
        check("waiting", waiting, 1'b0);
    endtask

    // band must follow the ramping setpoint, not the final target
    task automatic sc_mid();
        @(posedge clk);
        segment_target <= TGT + 16'h0100;
        segment_end_action <= pswq_pkg::wait_in_interval;
        set_pv(TGT);
        tick(2);
        check("waiting", waiting, 1'b0);
        @(posedge clk) current_setpoint <= TGT + 16'h0020;
        tick(2);
        check("waiting", waiting, 1'b1);
        tick(20);
        check("waiting", waiting, 1'b1);
        set_pv(TGT + 16'h000C);
        check("waiting", waiting, 1'b0);
        @(posedge clk);
        current_setpoint <= TGT;
        segment_target <= TGT;
        segment_end_action <= pswq_pkg::plain_continue;
        set_pv(TGT - 16'h0064);
    endtask

    task automatic sc_plain();
        // advance stands one cycle, so look right after the sampling edge
        seg_end(pswq_pkg::plain_continue);
        check("advance", advance, 1'b1);
        check("waiting", waiting, 1'b0);
        @(posedge clk) cfg.wait_enable <= 1'b0;
        seg_end(pswq_pkg::wait_at_switch);
        check("advance", advance, 1'b1);
        check("waiting", waiting, 1'b0);
        @(posedge clk) cfg.wait_enable <= 1'b1;
    endtask

    // links beyond two only with the extended option
    task automatic sc_links();
        for (int e = 0; e < 2; e++) begin
            for (int c = 6; c < 10; c++) begin
                @(posedge clk) extended_option <= e[0];
                // link_valid is a one-cycle pulse, seen just after the sampling edge
                seg_end(pswq_pkg::pswq_action_type'(c[3:0]));
                check("link_valid", link_valid, (e == 1) || (c < 8));
                if (link_valid === 1'b1) check("link_pattern", link_pattern, 16'(c - 6));
            end
        end
    endtask

    task automatic sc_cfg();
        @(posedge clk) cfg.upper_band_width <= 7'h64;
        tick(3);
        check("cfg_error", cfg_error, 1'b0);
        @(posedge clk) cfg.lower_band_width <= 7'h65;
        tick(3);
        check("cfg_error", cfg_error, 1'b1);
        @(posedge clk);
        cfg.lower_band_width <= 7'h14;
        cfg.program_time_unit <= pswq_pkg::minute_second_unit;
        cfg.timeout_major <= 10'h3E7;
        cfg.timeout_minor <= 6'h3B;
        tick(3);
        check("cfg_error", cfg_error, 1'b0);
        @(posedge clk) cfg.timeout_minor <= 6'h3C;
        tick(3);
        check("cfg_error", cfg_error, 1'b1);
    endtask

    // hold and local mode are sticky, so each starts from reset
    task automatic sc_end_actions();
        do_reset();
        @(posedge clk) current_setpoint <= TGT + 16'h0005;
        seg_end(pswq_pkg::hold_at_end);
        @(posedge clk) current_setpoint <= TGT + 16'h0040;
        tick(2);
        check("holding", holding, 1'b1);
        check("control_setpoint", control_setpoint, TGT + 16'h0005);
        do_reset();
        seg_end(pswq_pkg::release_then_local);
        tick(2);
        check("local_mode", local_mode, 1'b0);
        @(posedge clk) release_seen <= 1'b1;
        @(posedge clk) release_seen <= 1'b0;
        seg_end(pswq_pkg::release_then_local);
        tick(2);
        check("local_mode", local_mode, 1'b1);
        do_reset();
        seg_end(pswq_pkg::switch_to_local);
        tick(2);
        check("local_mode", local_mode, 1'b1);
        check("control_setpoint", control_setpoint, 16'h0123);
    endtask

    // main sequence
    initial begin
        {nrst, segment_end, release_seen, extended_option, slow} = '0;
        {current_setpoint, segment_target, goal} = {TGT, TGT, TGT};
        local_setpoint = 16'h0123;
        segment_end_action = pswq_pkg::plain_continue;
        cfg = '{1'b1, 7'h0A, 7'h14, 1'b1, 10'h000, 6'h00, pswq_pkg::hour_minute_unit};
        miscompares = 0;
        tests_run = 0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        sc_switch_wait();
        sc_timeout();
        sc_mid();
        sc_plain();
        sc_links();
        sc_cfg();
        sc_end_actions();
        summarize();
    end

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #5_000_000;
        miscompares++;
        summarize();
    end
endmodule
